// File: hubf_serial_top.sv
// Purpose: host serial port with programmable baud rate and fixed 8N1 framing
// Assumes: register strobes one cycle long, never together; ser_rx synchronous to mclk
// Notes:   a baud change takes effect at once, even mid-character
`timescale 1ns/1ps
`include "hubf_defs.svh"
module hubf_serial_top
    import hubf_pkg::*;
#(
    parameter int REF_HZ  = `HUBF_REF_HZ,
    parameter int MCLK_HZ = `HUBF_MCLK_HZ
) (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic [`HUBF_ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    input  wire logic                      ser_rx,
    output logic                           ser_tx
);
    logic            rst_meta;
    logic            rst_sync_n;
    hubf_top_state_t s_reg;
    hubf_top_state_t s_next;
    hubf_baud_if     tx_bif ();
    hubf_baud_if     rx_bif ();
    logic            tx_load;
    logic            rx_start;
    logic [7:0]      status;

    // reset is asserted at once, released only after two clean edges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // separate generators let the receiver realign its phase to each start edge
    assign tx_bif.setting = s_reg.baud;
    assign rx_bif.setting = s_reg.baud;
    assign tx_bif.restart = tx_load;
    assign rx_bif.restart = rx_start;

    hubf_baud_gen #(
        .REF_HZ  (REF_HZ),
        .MCLK_HZ (MCLK_HZ)
    ) u_tx_gen (
        .mclk  (mclk),
        .rst_n (rst_sync_n),
        .bif   (tx_bif)
    );

    hubf_baud_gen #(
        .REF_HZ  (REF_HZ),
        .MCLK_HZ (MCLK_HZ)
    ) u_rx_gen (
        .mclk  (mclk),
        .rst_n (rst_sync_n),
        .bif   (rx_bif)
    );

    always_comb begin
        status = 8'h00;
        status[`HUBF_ST_TX_BUSY]    = (s_reg.tx_state == HUBF_TX_SEND);
        status[`HUBF_ST_RX_VALID]   = s_reg.rx_valid;
        status[`HUBF_ST_RX_OVERRUN] = s_reg.rx_overrun;
        status[`HUBF_ST_FRAME_ERR]  = s_reg.frame_err;
        tx_load  = reg_wr && (reg_addr == `HUBF_OFS_TXDATA) && (s_reg.tx_state == HUBF_TX_IDLE);
        rx_start = (s_reg.rx_state == HUBF_RX_IDLE) && !ser_rx;
        s_next = s_reg;

        // register writes
        if (reg_wr && reg_addr == `HUBF_OFS_BAUD) begin
            s_next.baud = reg_wdata;
        end

        // read data stand for exactly the cycle after the strobe
        s_next.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `HUBF_OFS_BAUD) begin
                s_next.rdata = s_reg.baud;
            end else if (reg_addr == `HUBF_OFS_RXDATA) begin
                s_next.rdata    = s_reg.rx_data;
                s_next.rx_valid = 1'b0;
            end else if (reg_addr == `HUBF_OFS_STATUS) begin
                s_next.rdata      = status;
                s_next.rx_overrun = 1'b0;
                s_next.frame_err  = 1'b0;
            end else begin
                s_next.rdata = 8'h00;
            end
        end

        // transmitter: writes while busy are dropped, status shows busy
        case (s_reg.tx_state)
            HUBF_TX_IDLE: begin
                if (tx_load) begin
                    s_next.tx_shift = {1'b1, reg_wdata, 1'b0};
                    s_next.tx_cnt   = `HUBF_FRAME_BITS;
                    s_next.tx_phase = 1'b0;
                    s_next.tx_state = HUBF_TX_SEND;
                end
            end
            HUBF_TX_SEND: begin
                if (tx_bif.tick) begin
                    s_next.tx_phase = ~s_reg.tx_phase;
                    if (s_reg.tx_phase) begin
                        s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
                        s_next.tx_cnt   = s_reg.tx_cnt - 4'h1;
                        if (s_reg.tx_cnt == 4'h1) begin
                            s_next.tx_state = HUBF_TX_IDLE;
                        end
                    end
                end
            end
            default: s_next.tx_state = HUBF_TX_IDLE;
        endcase

        // receiver samples at mid-bit: every second half-bit tick
        case (s_reg.rx_state)
            HUBF_RX_IDLE: begin
                if (rx_start) begin
                    s_next.rx_cnt   = 4'h0;
                    s_next.rx_phase = 1'b0;
                    s_next.rx_state = HUBF_RX_RECV;
                end
            end
            HUBF_RX_RECV: begin
                if (rx_bif.tick) begin
                    s_next.rx_phase = ~s_reg.rx_phase;
                    if (!s_reg.rx_phase) begin
                        s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                        if (s_reg.rx_cnt == 4'h0) begin
                            // a glitch shorter than half a bit is no start
                            if (ser_rx) begin
                                s_next.rx_state = HUBF_RX_IDLE;
                            end
                        end else if (s_reg.rx_cnt <= 4'(`HUBF_DATA_BITS)) begin
                            s_next.rx_shift = {ser_rx, s_reg.rx_shift[7:1]};
                        end else begin
                            s_next.rx_state = HUBF_RX_IDLE;
                            if (ser_rx) begin
                                s_next.rx_data  = s_reg.rx_shift;
                                s_next.rx_valid = 1'b1;
                                // set wins over a clearing read in the same cycle
                                if (s_reg.rx_valid && !(reg_rd && reg_addr == `HUBF_OFS_RXDATA)) begin
                                    s_next.rx_overrun = 1'b1;
                                end
                            end else begin
                                s_next.frame_err = 1'b1;
                            end
                        end
                    end
                end
            end
            default: s_next.rx_state = HUBF_RX_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_reg          <= '0;
            s_reg.baud     <= `HUBF_BAUD_RESET;
            s_reg.tx_shift <= 10'h3FF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ser_tx    = s_reg.tx_shift[0];
    assign reg_rdata = s_reg.rdata;
endmodule

// File: hubf_defs.svh
// Purpose: register offsets, field positions, reset values and timing figures of the host serial port
// Assumes: registers sit at their printed byte offsets on the plain register port
// Notes:   definitions only
`ifndef HUBF_DEFS_SVH
`define HUBF_DEFS_SVH

`define HUBF_ADDR_W          8
`define HUBF_OFS_BAUD        8'h3B
`define HUBF_OFS_TXDATA      8'h60
`define HUBF_OFS_RXDATA      8'h61
`define HUBF_OFS_STATUS      8'h62

`define HUBF_BAUD_RESET      8'h7A
`define HUBF_EXP_HI          7
`define HUBF_EXP_LO          5
`define HUBF_MAN_HI          4
`define HUBF_MAN_LO          0
`define HUBF_OFFSET_ZERO_EXP 13'h0001
`define HUBF_OFFSET_EXP      13'h0021

`define HUBF_ST_TX_BUSY      0
`define HUBF_ST_RX_VALID     1
`define HUBF_ST_RX_OVERRUN   2
`define HUBF_ST_FRAME_ERR    3

`define HUBF_FRAME_BITS      4'hA
`define HUBF_DATA_BITS       8
`define HUBF_REF_HZ          27120000
`define HUBF_MCLK_HZ         10000000
`define HUBF_UNIT_HZ         10000
`define HUBF_MAX_BPS         1228800

`endif

// File: hubf_pkg.sv
// Purpose: types shared by the host serial port modules
// Assumes: nothing
// Notes:   state of each module is one packed struct
package hubf_pkg;

    typedef enum logic [0:0] {
        HUBF_TX_IDLE = 1'b0,
        HUBF_TX_SEND = 1'b1
    } hubf_tx_state_t;

    typedef enum logic [0:0] {
        HUBF_RX_IDLE = 1'b0,
        HUBF_RX_RECV = 1'b1
    } hubf_rx_state_t;

    typedef struct packed {
        logic [7:0]     baud;
        hubf_tx_state_t tx_state;
        logic [9:0]     tx_shift;
        logic [3:0]     tx_cnt;
        logic           tx_phase;
        hubf_rx_state_t rx_state;
        logic [7:0]     rx_shift;
        logic [3:0]     rx_cnt;
        logic           rx_phase;
        logic [7:0]     rx_data;
        logic           rx_valid;
        logic           rx_overrun;
        logic           frame_err;
        logic [7:0]     rdata;
    } hubf_top_state_t;

    typedef struct packed {
        logic [23:0] acc;
        logic        tick;
    } hubf_gen_state_t;

endpackage

// File: hubf_baud_if.sv
// Purpose: link between the serial engine and one half-bit tick generator
// Assumes: one clock domain
// Notes:   restart zeroes the phase so the first tick lands half a bit later
`timescale 1ns/1ps
interface hubf_baud_if;
    logic [7:0] setting;
    logic       restart;
    logic       tick;
    modport gen  (input setting, input restart, output tick);
    modport user (output setting, output restart, input tick);
endinterface

// File: hubf_baud_gen.sv
// Purpose: half-bit tick generator from the baud setting
// Assumes: mclk well above twice the highest supported bit rate
// Notes:   phase accumulator emulates division of the crystal clock on mclk
`timescale 1ns/1ps
`include "hubf_defs.svh"
module hubf_baud_gen
    import hubf_pkg::*;
#(
    parameter int REF_HZ  = `HUBF_REF_HZ,
    parameter int MCLK_HZ = `HUBF_MCLK_HZ
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    hubf_baud_if.gen   bif
);
    // two ticks per bit, counted in units of 10 kHz to keep the sums exact
    localparam logic [23:0] STEP      = 24'(2 * (REF_HZ / `HUBF_UNIT_HZ));
    localparam logic [23:0] CLK_UNITS = 24'(MCLK_HZ / `HUBF_UNIT_HZ);

    // four mclk edges per bit at the top rate, and exact 10 kHz units, or the sums drift
    if (MCLK_HZ < 4 * `HUBF_MAX_BPS ||
        (REF_HZ % `HUBF_UNIT_HZ) != 0 || (MCLK_HZ % `HUBF_UNIT_HZ) != 0) begin : g_rate_check
        $error("hubf_baud_gen: clock rates not served");
    end

    hubf_gen_state_t s_reg;
    hubf_gen_state_t s_next;
    logic [2:0]      exp_f;
    logic [4:0]      man_f;
    logic [12:0]     divisor;
    logic [23:0]     limit;
    logic [23:0]     sum;

    always_comb begin
        exp_f = bif.setting[`HUBF_EXP_HI:`HUBF_EXP_LO];
        man_f = bif.setting[`HUBF_MAN_HI:`HUBF_MAN_LO];
        if (exp_f == 3'h0) begin
            divisor = 13'(man_f) + `HUBF_OFFSET_ZERO_EXP;
        end else begin
            divisor = 13'((13'(man_f) + `HUBF_OFFSET_EXP) << (exp_f - 3'h1));
        end
        limit  = 24'(divisor) * CLK_UNITS;
        sum    = s_reg.acc + STEP;
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (bif.restart) begin
            s_next.acc = 24'h000000;
        end else if (sum >= limit) begin
            s_next.tick = 1'b1;
            // a setting faster than mclk can follow saturates instead of wrapping
            s_next.acc = (sum - limit >= limit) ? 24'h000000 : sum - limit;
        end else begin
            s_next.acc = sum;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bif.tick = s_reg.tick;
endmodule

// File: hubf_serial_top_props.sv
// Purpose: port-level properties of the host serial port
// Assumes: baud setting is only rewritten while the line is idle
// Notes:   bit widths in mclk cycles, two cycles of slack on the shortest bit and three on the longest low run, for tick jitter
`timescale 1ns/1ps
module hubf_serial_props (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ser_rx,
    input wire logic       ser_tx
);
    logic [7:0]  baud_reg;
    logic        sent_reg;
    logic [15:0] low_reg;
    int          bitc;
    always_comb begin
        bitc = ((baud_reg[7:5] == 3'h0) ? int'(baud_reg[4:0]) + 1
               : (int'(baud_reg[4:0]) + 33) << (baud_reg[7:5] - 3'h1)) * 1000 / 2712;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            baud_reg <= 8'h7A;
            sent_reg <= 1'b0;
            low_reg  <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == 8'h3B) baud_reg <= reg_wdata;
            if (reg_wr && reg_addr == 8'h60) sent_reg <= 1'b1;
            low_reg <= ser_tx ? 16'h0000 : low_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_baud_wr; reg_wr && reg_addr == 8'h3B; endsequence
    sequence s_baud_rd; reg_rd && reg_addr == 8'h3B; endsequence
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_baud_read; s_baud_rd |=> reg_rdata == $past(baud_reg); endproperty
    property p_wr_rd; s_baud_wr ##1 s_baud_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
    property p_unmapped; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
    property p_idle_high; !sent_reg |-> ser_tx; endproperty
    property p_tx_start; reg_wr && reg_addr == 8'h60 && !sent_reg |=> !ser_tx [*7]; endproperty
    property p_min_zero; $rose(ser_tx) && baud_reg[7:5] == 3'h0 |-> low_reg >= bitc - 2; endproperty
    property p_min_exp; $rose(ser_tx) && baud_reg[7:5] != 3'h0 |-> low_reg >= bitc - 2; endproperty
    property p_max_low; !ser_tx |-> low_reg <= 9 * bitc + 3; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
    a_baud_read: assert property (p_baud_read) else $error("baud register read wrong");
    a_wr_rd: assert property (p_wr_rd) else $error("baud fields not kept");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");
    a_tx_start: assert property (p_tx_start) else $error("start bit missing");
    a_min_zero: assert property (p_min_zero) else $error("bit too short, zero exponent");
    a_min_exp: assert property (p_min_exp) else $error("bit too short, exponent set");
    a_max_low: assert property (p_max_low) else $error("no stop bit");
endmodule
bind hubf_serial_top hubf_serial_props i_props (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ser_rx(ser_rx), .ser_tx(ser_tx));

// File: hubf_host_model.sv
// Purpose: host microcontroller serial port facing the block
// Assumes: bit_ns set by the bench before each character
// Notes:   edges follow mclk, so each bit edge may lag by one mclk period
`timescale 1ns/1ps
module hubf_host_model (
    input  wire logic mclk,
    input  wire logic ser_tx,
    output logic      ser_rx
);
    int         bit_ns;
    logic [7:0] got_q[$];
    logic       stop_q[$];
    int         width_q[$];
    realtime    t0;
    logic [8:0] sh;
    initial begin
        bit_ns = 8681;
        ser_rx = 1'b1;
    end
    task automatic at(input realtime t);
        while ($realtime < t) @(posedge mclk);
    endtask
    task automatic send(input logic [7:0] b, input logic stp);
        realtime ts;
        ts = $realtime;
        for (int i = 0; i < 10; i++) begin
            at(ts + i * bit_ns);
            ser_rx <= (i == 0) ? 1'b0 : ((i == 9) ? stp : b[i - 1]);
        end
        at(ts + 10 * bit_ns);
        // a broken stop bit must not leave the line low
        ser_rx <= 1'b1;
    endtask
    always begin
        @(negedge ser_tx);
        t0 = $realtime;
        @(negedge mclk);
        while (!ser_tx) @(negedge mclk);
        width_q.push_back(int'($realtime - t0));
        for (int i = 0; i < 9; i++) begin
            while ($realtime < t0 + (i + 1.5) * bit_ns) @(negedge mclk);
            sh = {ser_tx, sh[8:1]};
        end
        got_q.push_back(sh[7:0]);
        stop_q.push_back(sh[8]);
    end
endmodule

// File: tb_host_uart_baud_framing.sv
// Purpose: self-checking bench of the host serial port
// Assumes: first data bit of each sent byte is one, so the start bit width is measurable
// Notes:   random baud settings keep the exponent at 1..4 to bound run time
`timescale 1ns/1ps
module tb_host_uart_baud_framing;
    logic        mclk, nrst, reg_wr, reg_rd, ser_tx, ser_rx;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, d;
    logic [31:0] seed;
    int          err_total, comparisons, k, n, bit_ns, dv;
    int          nom[4] = '{9600, 115200, 921600, 1228800};
    logic [7:0]  tbl[4] = '{8'hEB, 8'h7A, 8'h1C, 8'h15};
    hubf_serial_top i_hubf_serial_top (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_rx(ser_rx), .ser_tx(ser_tx));
    hubf_host_model u_host (.mclk(mclk), .ser_tx(ser_tx), .ser_rx(ser_rx));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        reg_addr  <= a;
        reg_wdata <= dat;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        q = reg_rdata;
        @(posedge mclk);
    endtask
    task automatic wait_host;
        for (n = 0; n < 20000 && u_host.got_q.size() == 0; n++) @(posedge mclk);
        if (u_host.got_q.size() == 0) begin
            err_total++;
            results;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        nrst      = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        seed      = 32'h6704128F;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(8'h3B, v);
        chk(v, 8'h7A);
        rd(8'h00, v);
        chk(v, 8'h00);
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            d = (k < 4) ? tbl[k] : {3'(seed[6:5]) + 3'h1, seed[4:0]};
            wr(8'h3B, d);
            rd(8'h3B, v);
            chk(v, d);
            dv = (d[7:5] == 3'h0) ? d[4:0] + 1 : (d[4:0] + 33) << (d[7:5] - 3'h1);
            bit_ns = (k < 4) ? 1000000000 / nom[k] : dv * 100000 / 2712;
            u_host.bit_ns = bit_ns;
            d = seed[15:8] | 8'h01;
            wr(8'h60, d);
            @(posedge mclk);
            wr(8'h60, ~d);
            rd(8'h62, v);
            chk(v[0], 1'b1);
            wait_host;
            chk(u_host.got_q.pop_front(), d);
            chk(u_host.stop_q.pop_front(), 1'b1);
            n = u_host.width_q.pop_front() - bit_ns;
            chk(n <= bit_ns / 100 + 250 && n >= -(bit_ns / 100 + 250), 1'b1);
            repeat (bit_ns * 11 / 100) @(posedge mclk);
            chk(u_host.got_q.size(), 0);
            d = seed[23:16];
            u_host.send(d, 1'b1);
            rd(8'h62, v);
            chk(v[1], 1'b1);
            chk(v[0], 1'b0);
            rd(8'h61, v);
            chk(v, d);
        end
        u_host.send(8'hA5, 1'b0);
        rd(8'h62, v);
        chk(v[3:1], 3'b100);
        repeat (bit_ns / 50) @(posedge mclk);
        u_host.send(8'h3C, 1'b1);
        u_host.send(8'hC3, 1'b1);
        rd(8'h62, v);
        chk(v[3:1], 3'b011);
        rd(8'h61, v);
        chk(v, 8'hC3);
        results;
    end
endmodule
